// file: pclcp_map.vh
// Purpose: constants for the control list record processor
// Assumes: 32-bit host memory words, byte addresses
// Notes: included by both design files
`ifndef PCLCP_MAP_VH
`define PCLCP_MAP_VH
// Record offsets
`define PCLCP_OFS_LINK 32'h00000000
`define PCLCP_OFS_STATUS 32'h0000000C
`define PCLCP_OFS_FIRST_CMD 32'h00000018
`define PCLCP_OFS_LAST_PARM 32'h0000007C
// Command word fields
`define PCLCP_CMD_HI 27
`define PCLCP_CMD_LO 24
`define PCLCP_SEL_HI 22
`define PCLCP_SEL_LO 20
`define PCLCP_BIT_INT 19
`define PCLCP_BIT_LAST 18
`define PCLCP_BIT_WSTAT 17
`define PCLCP_BIT_BIGEND 16
`define PCLCP_BIT_MULTI 13
`define PCLCP_BIT_ISO 12
`define PCLCP_CNT_HI 11
// Auxiliary opcodes
`define PCLCP_OP_NOP 4'h0
`define PCLCP_OP_LOAD 4'h3
`define PCLCP_OP_STQ 4'h4
`define PCLCP_OP_STD 4'hB
`define PCLCP_OP_ST0 4'h5
`define PCLCP_OP_ST1 4'h6
`define PCLCP_OP_BRANCH 4'h7
`define PCLCP_OP_ADD 4'hD
`define PCLCP_OP_CMP 4'hE
`define PCLCP_OP_SWAP 4'hF
// Transfer opcodes
`define PCLCP_OP_RCV 4'h1
`define PCLCP_OP_RCVU 4'hA
`define PCLCP_OP_XMT 4'h2
`define PCLCP_OP_RAWX 4'hC
`define PCLCP_OP_H2L 4'h8
`define PCLCP_OP_L2H 4'h9
// Wait and condition selects
`define PCLCP_SEL_NONE 3'h0
`define PCLCP_SEL_RDY1 3'h1
`define PCLCP_SEL_RDY0 3'h2
`define PCLCP_SEL_EXT1 3'h3
`define PCLCP_SEL_EXT0 3'h4
`define PCLCP_SEL_GP2 3'h5
`define PCLCP_SEL_GP3 3'h6
// Status word pieces
`define PCLCP_STAT_MSTERR 32'h20000000
`define PCLCP_STAT_CMP 32'h08000000
// Memory lane enables
`define PCLCP_BE_QUAD 4'hF
`define PCLCP_BE_DBL 4'h3
`endif

// file: pclcp_wait_eval.v
// Purpose: evaluates wait selects and branch conditions
// Assumes: all inputs synchronous to clk
// Notes: reserved codes give hold=0 for waits, false for branches
`timescale 1ns/1ps
`include "pclcp_map.vh"
module pclcp_wait_eval (
  // Select code and mode
  input wire [2:0] sel,
  input wire is_branch,
  // Condition sources
  input wire ready_flag,
  input wire ext_ready,
  input wire gp2_active,
  input wire gp3_active,
  // Result
  output reg cond_true
);
  // Condition decode
  always @* begin
    case (sel)
      `PCLCP_SEL_NONE: cond_true = ~is_branch;
      `PCLCP_SEL_RDY1: cond_true = ready_flag;
      `PCLCP_SEL_RDY0: cond_true = ~ready_flag;
      `PCLCP_SEL_EXT1: cond_true = ext_ready;
      `PCLCP_SEL_EXT0: cond_true = ~ext_ready;
      `PCLCP_SEL_GP2: cond_true = gp2_active;
      `PCLCP_SEL_GP3: cond_true = gp3_active;
      default: cond_true = ~is_branch;
    endcase
  end
endmodule

// file: pclcp_processor.v
// Purpose: fetches and executes control list records
// Assumes: one-word memory master, reads answer with mem_ack
// Notes: transfer data movement is handed to outside logic
// Functional notes
// - Bit 13 allows several iso packets per cycle
// - Bit 12 selects iso transmit
// - Sum buffer lengths up to final buffer
// - Local transfers use local base address
// - Bit 18 ends buffer gathering
// - Bit 16 selects byte lane order
// - Aux record: link 0, status C, pairs 18-7C
// - Decode aux opcode bits 27-24
// - Load, store quad/double, zeros, ones
// - Wait select gates load and stores
// - Branch condition selects destination record
// - Status and interrupt before branch
// - Interrupt on bit 19 or master fault
// - Bit 18 marks final aux command
// - Parameter loads data buffer address register
// - Masked compare writes ready flag
// - Swap scratch halves then compare
// - Add three-bit addend to scratch
// - Busy ack reruns whole record
// - Status reflects last executed command
// - Link bit 0 set means invalid
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "pclcp_map.vh"
module pclcp_processor #(
  parameter AW = 32
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Software command port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Host memory master
  output reg mem_req,
  output reg mem_we,
  output reg [AW-1:0] mem_addr,
  output reg [31:0] mem_wdata,
  output reg [3:0] mem_be,
  input wire mem_ack,
  input wire mem_err,
  input wire [31:0] mem_rdata,
  // Wait and branch sources
  input wire ext_ready,
  input wire gp2_active,
  input wire gp3_active,
  // Transfer engine handoff
  output reg xfer_start,
  output reg [3:0] xfer_cmd,
  output reg xfer_iso,
  output reg xfer_multi,
  output reg xfer_big_endian,
  output reg xfer_wait_status,
  output reg [AW-1:0] xfer_host_addr,
  output reg [AW-1:0] xfer_local_addr,
  output reg [15:0] xfer_total_len,
  input wire xfer_done,
  input wire xfer_busy_ack,
  input wire [31:0] xfer_status,
  // Events
  output reg pcl_irq,
  output reg halt_irq
);
  // Software register indexes
  localparam [3:0] R_CTRL = 4'h0;
  localparam [3:0] R_LIST = 4'h1;
  localparam [3:0] R_LBASE = 4'h2;
  localparam [3:0] R_SCRATCH = 4'h3;
  localparam [3:0] R_READY = 4'h4;
  localparam [3:0] R_STATE = 4'h5;
  // States
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_LINK = 4'h1;
  localparam [3:0] S_CMD = 4'h2;
  localparam [3:0] S_PARM = 4'h3;
  localparam [3:0] S_EXEC = 4'h4;
  localparam [3:0] S_MEM = 4'h5;
  localparam [3:0] S_STAT = 4'h6;
  localparam [3:0] S_NEXT = 4'h7;
  localparam [3:0] S_XCTL = 4'h8;
  localparam [3:0] S_XPTR = 4'h9;
  localparam [3:0] S_XRUN = 4'hA;
  localparam [3:0] S_HALT = 4'hB;

  // Sum of three-bit addend into scratch
  function [31:0] add_small;
    input [31:0] a;
    input [2:0] b;
    begin
      add_small = a + {29'h0000000, b};
    end
  endfunction

  // Masked compare of low half
  function masked_eq;
    input [31:0] tmp;
    input [31:0] prm;
    begin
      masked_eq = ~|((tmp[15:0] ^ prm[15:0]) & prm[31:16]);
    end
  endfunction

  reg [3:0] state; // Current state
  reg enable; // Channel enable from software
  reg [AW-1:0] rec_addr; // Current record address
  reg [AW-1:0] list_ptr; // Software list pointer
  reg [AW-1:0] lbase; // Local bus base address
  reg [AW-1:0] word_addr; // Next command word address
  reg [31:0] scratch; // Scratch register
  reg ready_flag; // Ready flag bit 0
  reg [31:0] cmd_word; // Latched command word
  reg [31:0] buf_addr; // Current data buffer address
  reg [31:0] first_ctl; // First transfer control word
  reg [15:0] len_sum; // Gathered length
  reg branch_taken; // Branch pending after status
  reg mst_err; // Master fault seen
  reg [31:0] status_word; // Status to write
  wire [3:0] op; // Opcode field
  wire cond_true; // Wait or branch condition
  wire is_xfer; // Transfer opcode

  assign op = cmd_word[`PCLCP_CMD_HI:`PCLCP_CMD_LO];
  assign is_xfer = (op == `PCLCP_OP_RCV) || (op == `PCLCP_OP_RCVU) ||
                   (op == `PCLCP_OP_XMT) || (op == `PCLCP_OP_RAWX) ||
                   (op == `PCLCP_OP_H2L) || (op == `PCLCP_OP_L2H);

  // Condition evaluation
  pclcp_wait_eval u_wait (
    .sel(cmd_word[`PCLCP_SEL_HI:`PCLCP_SEL_LO]),
    .is_branch(op == `PCLCP_OP_BRANCH),
    .ready_flag(ready_flag),
    .ext_ready(ext_ready),
    .gp2_active(gp2_active),
    .gp3_active(gp3_active),
    .cond_true(cond_true)
  );

  // Software read port, data one cycle later
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        R_CTRL: reg_rdata <= {31'h00000000, enable};
        R_LIST: reg_rdata <= list_ptr;
        R_LBASE: reg_rdata <= lbase;
        R_SCRATCH: reg_rdata <= scratch;
        R_READY: reg_rdata <= {31'h00000000, ready_flag};
        R_STATE: reg_rdata <= {28'h0000000, state};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Main sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      enable <= 1'b0;
      rec_addr <= 32'h00000000;
      list_ptr <= 32'h00000001;
      lbase <= 32'h00000000;
      word_addr <= 32'h00000000;
      scratch <= 32'h00000000;
      ready_flag <= 1'b0;
      cmd_word <= 32'h00000000;
      buf_addr <= 32'h00000000;
      first_ctl <= 32'h00000000;
      len_sum <= 16'h0000;
      branch_taken <= 1'b0;
      mst_err <= 1'b0;
      status_word <= 32'h00000000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      mem_be <= 4'h0;
      xfer_start <= 1'b0;
      xfer_cmd <= 4'h0;
      xfer_iso <= 1'b0;
      xfer_multi <= 1'b0;
      xfer_big_endian <= 1'b0;
      xfer_wait_status <= 1'b0;
      xfer_host_addr <= 32'h00000000;
      xfer_local_addr <= 32'h00000000;
      xfer_total_len <= 16'h0000;
      pcl_irq <= 1'b0;
      halt_irq <= 1'b0;
    end else begin
      xfer_start <= 1'b0;
      pcl_irq <= 1'b0;
      halt_irq <= 1'b0;
      // Software writes
      if (reg_wr) begin
        case (reg_addr)
          R_CTRL: enable <= reg_wdata[0];
          R_LIST: list_ptr <= reg_wdata;
          R_LBASE: lbase <= reg_wdata;
          R_SCRATCH: scratch <= reg_wdata;
          R_READY: ready_flag <= reg_wdata[0];
          default: ;
        endcase
      end
      case (state)
        // Wait for a valid pointer and enable
        S_IDLE: begin
          if (enable && !list_ptr[0]) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= list_ptr + `PCLCP_OFS_LINK;
            state <= S_LINK;
          end
        end
        // Link word of pointed record
        S_LINK: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (mem_err || mem_rdata[0]) begin
              state <= S_HALT;
            end else begin
              rec_addr <= mem_rdata;
              word_addr <= mem_rdata + `PCLCP_OFS_FIRST_CMD;
              mem_req <= 1'b1;
              mem_addr <= mem_rdata + `PCLCP_OFS_FIRST_CMD;
              state <= S_CMD;
            end
          end
        end
        // Command word
        S_CMD: begin
          if (mem_ack) begin
            cmd_word <= mem_rdata;
            mem_addr <= word_addr + 32'h00000004;
            word_addr <= word_addr + 32'h00000008;
            mst_err <= mem_err;
            state <= mem_err ? S_STAT : S_PARM;
            mem_req <= ~mem_err;
          end
        end
        // Parameter word
        S_PARM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            buf_addr <= mem_rdata;
            mst_err <= mem_err;
            if (mem_err) begin
              state <= S_STAT;
            end else if (is_xfer) begin
              first_ctl <= cmd_word;
              len_sum <= {4'h0, cmd_word[`PCLCP_CNT_HI:0]};
              xfer_host_addr <= mem_rdata;
              if (cmd_word[`PCLCP_BIT_LAST]) begin
                state <= S_XRUN;
                xfer_start <= 1'b1;
                xfer_total_len <= {4'h0, cmd_word[`PCLCP_CNT_HI:0]};
              end else begin
                mem_req <= 1'b1;
                mem_addr <= word_addr;
                state <= S_XCTL;
              end
            end else begin
              state <= S_EXEC;
            end
          end
        end
        // Execute one auxiliary command
        S_EXEC: begin
          case (op)
            `PCLCP_OP_LOAD, `PCLCP_OP_STQ, `PCLCP_OP_STD,
            `PCLCP_OP_ST0, `PCLCP_OP_ST1: begin
              if (cond_true) begin
                mem_req <= 1'b1;
                mem_addr <= buf_addr;
                mem_we <= (op != `PCLCP_OP_LOAD);
                mem_be <= (op == `PCLCP_OP_STD) ? `PCLCP_BE_DBL :
                          `PCLCP_BE_QUAD;
                mem_wdata <= (op == `PCLCP_OP_ST0) ? 32'h00000000 :
                             (op == `PCLCP_OP_ST1) ? 32'hFFFFFFFF :
                             scratch;
                state <= S_MEM;
              end
            end
            `PCLCP_OP_ADD: begin
              scratch <= add_small(scratch, buf_addr[2:0]);
              state <= S_NEXT;
            end
            `PCLCP_OP_CMP: begin
              ready_flag <= masked_eq(scratch, buf_addr);
              state <= S_NEXT;
            end
            `PCLCP_OP_SWAP: begin
              scratch <= {scratch[15:0], scratch[31:16]};
              ready_flag <= masked_eq({scratch[15:0], scratch[31:16]},
                                      buf_addr);
              state <= S_NEXT;
            end
            `PCLCP_OP_BRANCH: begin
              branch_taken <= cond_true;
              state <= cond_true ? S_STAT : S_NEXT;
            end
            default: state <= S_NEXT;
          endcase
        end
        // Memory access of load or store
        S_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mst_err <= mem_err;
            if (op == `PCLCP_OP_LOAD && !mem_err) begin
              scratch <= mem_rdata;
            end
            state <= mem_err ? S_STAT : S_NEXT;
          end
        end
        // Following command or finish record
        S_NEXT: begin
          if (cmd_word[`PCLCP_BIT_LAST] ||
              word_addr > rec_addr + `PCLCP_OFS_LAST_PARM) begin
            state <= S_STAT;
          end else begin
            mem_req <= 1'b1;
            mem_addr <= word_addr;
            state <= S_CMD;
          end
        end
        // Gather following buffer control words
        S_XCTL: begin
          if (mem_ack) begin
            mem_addr <= word_addr + 32'h00000004;
            word_addr <= word_addr + 32'h00000008;
            len_sum <= len_sum + {4'h0, mem_rdata[`PCLCP_CNT_HI:0]};
            mst_err <= mem_err;
            if (mem_err) begin
              mem_req <= 1'b0;
              state <= S_STAT;
            end else begin
              mem_req <= 1'b1;
              cmd_word <= mem_rdata;
              state <= S_XPTR;
            end
          end
        end
        // Buffer pointer after a control word
        S_XPTR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mst_err <= mem_err;
            if (mem_err) begin
              state <= S_STAT;
            end else if (cmd_word[`PCLCP_BIT_LAST]) begin
              xfer_start <= 1'b1;
              xfer_total_len <= len_sum;
              state <= S_XRUN;
            end else begin
              mem_req <= 1'b1;
              mem_addr <= word_addr;
              state <= S_XCTL;
            end
          end
        end
        // Transfer owned by the data engine
        S_XRUN: begin
          xfer_cmd <= first_ctl[`PCLCP_CMD_HI:`PCLCP_CMD_LO];
          xfer_iso <= first_ctl[`PCLCP_BIT_ISO] &&
                      (first_ctl[27:24] == `PCLCP_OP_XMT ||
                       first_ctl[27:24] == `PCLCP_OP_RAWX);
          xfer_multi <= first_ctl[`PCLCP_BIT_MULTI] &&
                        (first_ctl[27:24] == `PCLCP_OP_XMT ||
                         first_ctl[27:24] == `PCLCP_OP_RAWX);
          xfer_big_endian <= first_ctl[`PCLCP_BIT_BIGEND];
          xfer_wait_status <= first_ctl[`PCLCP_BIT_WSTAT];
          xfer_local_addr <= lbase;
          if (xfer_busy_ack) begin
            mem_req <= 1'b1;
            mem_addr <= rec_addr + `PCLCP_OFS_FIRST_CMD;
            word_addr <= rec_addr + `PCLCP_OFS_FIRST_CMD;
            state <= S_CMD;
          end else if (xfer_done) begin
            status_word <= xfer_status;
            cmd_word <= first_ctl;
            state <= S_STAT;
          end
        end
        // Write record status
        S_STAT: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_be <= `PCLCP_BE_QUAD;
            mem_addr <= rec_addr + `PCLCP_OFS_STATUS;
            mem_wdata <= mst_err ? `PCLCP_STAT_MSTERR :
                         is_xfer ? status_word : `PCLCP_STAT_CMP;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            pcl_irq <= cmd_word[`PCLCP_BIT_INT] | mst_err;
            if (mst_err) begin
              state <= S_HALT;
            end else if (branch_taken) begin
              branch_taken <= 1'b0;
              list_ptr <= buf_addr;
              state <= S_IDLE;
            end else begin
              list_ptr <= rec_addr;
              state <= S_IDLE;
            end
          end
        end
        // Channel stops
        S_HALT: begin
          halt_irq <= 1'b1;
          enable <= 1'b0;
          mst_err <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// file: pclcp_asserts.sv
// Purpose: port-level checks on the record processor
// Assumes: one clock, asynchronous active-high reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module pclcp_asserts #(
  parameter AW = 32
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Memory master
  input wire mem_req,
  input wire mem_we,
  input wire [AW-1:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] mem_be,
  input wire mem_ack,
  // Transfer handoff and events
  input wire xfer_start,
  input wire [3:0] xfer_cmd,
  input wire [15:0] xfer_total_len,
  input wire xfer_done,
  input wire pcl_irq,
  input wire halt_irq
);
  // Cycles since the last acknowledged write
  reg [3:0] wr_age;
  // High while a transfer is out with the link side
  reg busy;
  // Age and busy trackers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_age <= 4'hF;
      busy <= 1'b0;
    end else begin
      if (mem_req && mem_we && mem_ack) begin
        wr_age <= 4'h0;
      end else if (wr_age != 4'hF) begin
        wr_age <= wr_age + 4'h1;
      end
      if (xfer_start) begin
        busy <= 1'b1;
      end else if (xfer_done) begin
        busy <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request dropped or changed before answer");
  a_store_lanes: assert property (mem_req && mem_we |->
    mem_be == 4'hF || mem_be == 4'h3)
    else $error("write lanes neither quad nor double");
  a_irq_status: assert property (pcl_irq |-> wr_age < 4'h3)
    else $error("completion event without a status write");
  a_irq_single: assert property (pcl_irq |=> !pcl_irq)
    else $error("completion event longer than one cycle");
  a_start_single: assert property (xfer_start |=> !xfer_start)
    else $error("transfer start longer than one cycle");
  a_fields_hold: assert property (!xfer_start ##1 !xfer_start |->
    $stable(xfer_total_len) && $stable(xfer_cmd))
    else $error("transfer fields moved without a start");
  a_halt_single: assert property (halt_irq |=> !halt_irq)
    else $error("halt event longer than one cycle");
  a_wait_done: assert property (busy |-> !xfer_start &&
    !(mem_req && mem_we)) else $error("activity before transfer done");
endmodule

// file: pclcp_host_mem.sv
// Purpose: host memory and link side model for the processor
// Assumes: 4 KB word store, one request at a time
// Notes: read data turn over on every clock that loads no read answer
`timescale 1ns/1ps
module pclcp_host_mem #(
  parameter AW = 32,
  parameter XSTAT = 32'h08000000
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Memory slave side
  input wire mem_req,
  input wire mem_we,
  input wire [AW-1:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0] mem_be,
  output logic mem_ack,
  output logic mem_err,
  output logic [31:0] mem_rdata,
  // Link side of the handoff
  input wire xfer_start,
  output logic xfer_done,
  output logic xfer_busy_ack,
  output logic [31:0] xfer_status
);
  // Word store, answer delay, alternation and transfer timer
  logic [31:0] mem [0:1023];
  int dly, slow, xcnt;
  // Invalid link pattern everywhere to start
  initial for (int i = 0; i < 1024; i++) mem[i] <= 32'h00000001;
  // Master fault on any access to the word at FFC
  assign mem_err = mem_ack && (mem_addr[11:0] == 12'hFFC);
  assign xfer_busy_ack = 1'b0;
  assign xfer_status = XSTAT;
  // Answer each request after zero or two waits, alternating from the second request on
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h00000000;
      dly <= 0;
      slow <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && dly != 0) begin
        dly <= dly - 1;
      end else if (mem_req && !mem_ack) begin
        mem_ack <= 1'b1;
        slow <= 1 - slow;
        dly <= slow * 2;
        if (!mem_we) begin
          mem_rdata <= mem[mem_addr[11:2]];
        end
        for (int b = 0; b < 4; b++) begin
          if (mem_we && mem_be[b]) begin
            mem[mem_addr[11:2]][8*b+:8] <= mem_wdata[8*b+:8];
          end
        end
      end
    end
  end
  // Link finishes a transfer seven cycles after start
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xcnt <= 0;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= (xcnt == 1);
      if (xfer_start) begin
        xcnt <= 6;
      end else if (xcnt != 0) begin
        xcnt <= xcnt - 1;
      end
    end
  end
endmodule

// file: pclcp_tb.sv
// Purpose: self-checking bench for the record processor
// Assumes: 25 MHz clock, records built in the memory model
// Notes: one task per scenario
`timescale 1ns/1ps
module tb;
  // Clock, reset, register port and condition sources
  logic clk, sys_rst, reg_wr, reg_rd, ext_ready, gp2_active, gp3_active;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  // Memory and handoff wiring
  wire mem_req, mem_we, mem_ack, mem_err, pcl_irq, halt_irq;
  wire xfer_start, xfer_iso, xfer_multi, xfer_big_endian;
  wire xfer_wait_status, xfer_done, xfer_busy_ack;
  wire [3:0] mem_be, xfer_cmd;
  wire [31:0] mem_addr, mem_wdata, mem_rdata, xfer_status;
  wire [31:0] xfer_host_addr, xfer_local_addr;
  wire [15:0] xfer_total_len;
  // Tallies
  int errors = 0, n_tests = 0, cycles = 0;
  int irq_cnt = 0, halt_cnt = 0, start_cnt = 0;
  pclcp_processor #(.AW(32)) pclcp_processor_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .ext_ready(ext_ready), .gp2_active(gp2_active), .gp3_active(gp3_active),
    .xfer_start(xfer_start), .xfer_cmd(xfer_cmd), .xfer_iso(xfer_iso),
    .xfer_multi(xfer_multi), .xfer_big_endian(xfer_big_endian),
    .xfer_wait_status(xfer_wait_status),
    .xfer_host_addr(xfer_host_addr), .xfer_local_addr(xfer_local_addr),
    .xfer_total_len(xfer_total_len), .xfer_done(xfer_done),
    .xfer_busy_ack(xfer_busy_ack), .xfer_status(xfer_status),
    .pcl_irq(pcl_irq), .halt_irq(halt_irq));
  pclcp_host_mem #(.AW(32)) pclcp_host_mem_i (
    .clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .xfer_start(xfer_start), .xfer_done(xfer_done),
    .xfer_busy_ack(xfer_busy_ack), .xfer_status(xfer_status));
  // 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Event tallies and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (pcl_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (halt_irq === 1'b1) halt_cnt <= halt_cnt + 1;
    if (xfer_start === 1'b1) start_cnt <= start_cnt + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read, then judge the word in the following cycle
  task rdc(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic wait_cnt(string n, ref int c, input int t);
    repeat (2000) begin
      @(negedge clk);
      if (c >= t) break;
    end
    chk(n, t, c);
  endtask
  task put(input logic [11:0] a, input logic [31:0] d);
    pclcp_host_mem_i.mem[a[11:2]] <= d;
  endtask
  function logic [31:0] get(input logic [11:0] a);
    return pclcp_host_mem_i.mem[a[11:2]];
  endfunction
  task t_regs;
    rdc("list reset", 4'h1, 32'h00000001);
    wr(4'h2, 32'h0000C000);
    wr(4'h3, 32'hA5A55A5A);
    rdc("scratch", 4'h3, 32'hA5A55A5A);
    rdc("unmapped", 4'hF, 32'h00000000);
    $display("test registers done");
  endtask
  task t_aux;
    put(12'h0F0, 32'h00000100);
    put(12'h200, 32'h1234FFFE);
    put(12'h214, 32'hAAAAAAAA);
    put(12'h218, 32'hFFFFFFFF);
    put(12'h118, 32'h03000000);
    put(12'h11C, 32'h00000200);
    put(12'h120, 32'h0D000000);
    put(12'h124, 32'h00000005);
    put(12'h128, 32'h04300000);
    put(12'h12C, 32'h00000210);
    put(12'h130, 32'h0B600000);
    put(12'h134, 32'h00000214);
    put(12'h138, 32'h05000000);
    put(12'h13C, 32'h00000218);
    put(12'h140, 32'h06000000);
    put(12'h144, 32'h0000021C);
    put(12'h148, 32'h0E000000);
    put(12'h14C, 32'hFFFF0003);
    put(12'h150, 32'h0F0C0000);
    put(12'h154, 32'h00FF0035);
    put(12'h158, 32'h06000000);
    put(12'h15C, 32'h00000220);
    wr(4'h1, 32'h000000F0);
    wr(4'h0, 32'h00000001);
    repeat (60) @(negedge clk);
    chk("held store", 32'h00000001, get(12'h210));
    @(posedge clk);
    ext_ready <= 1'b1;
    gp3_active <= 1'b1;
    wait_cnt("halt count", halt_cnt, 1);
    chk("store quad", 32'h12350003, get(12'h210));
    chk("store double", 32'hAAAA0003, get(12'h214));
    chk("store zeros", 32'h00000000, get(12'h218));
    chk("store ones", 32'hFFFFFFFF, get(12'h21C));
    chk("after last", 32'h00000001, get(12'h220));
    chk("status", 32'h08000000, get(12'h10C));
    chk("irq count", 32'h1, irq_cnt);
    rdc("scratch", 4'h3, 32'h00031235);
    rdc("ready", 4'h4, 32'h00000001);
    $display("test auxiliary done");
  endtask
  task t_branch;
    put(12'h2F0, 32'h00000300);
    put(12'h318, 32'h07580000);
    put(12'h31C, 32'h000003F0);
    put(12'h3F0, 32'h00000500);
    put(12'h500, 32'h00000600);
    put(12'h618, 32'h03040000);
    put(12'h61C, 32'h00000FFC);
    put(12'h518, 32'h020B3010);
    put(12'h51C, 32'h00008000);
    put(12'h520, 32'h000500FF);
    put(12'h524, 32'h00009000);
    @(posedge clk);
    gp2_active <= 1'b1;
    wr(4'h1, 32'h000002F0);
    wr(4'h0, 32'h00000001);
    wait_cnt("starts", start_cnt, 1);
    chk("command", 32'h2, xfer_cmd);
    chk("iso", 32'h1, xfer_iso);
    chk("multi", 32'h1, xfer_multi);
    chk("byte order", 32'h1, xfer_big_endian);
    chk("length", 32'h010F, xfer_total_len);
    chk("host address", 32'h00008000, xfer_host_addr);
    chk("local address", 32'h0000C000, xfer_local_addr);
    chk("wait status", 32'h1, xfer_wait_status);
    wait_cnt("halt count", halt_cnt, 2);
    chk("branch status", 32'h08000000, get(12'h30C));
    chk("fault status", 32'h20000000, get(12'h60C));
    chk("irq count", 32'h4, irq_cnt);
    $display("test branch and transfer done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    ext_ready = 1'b0;
    gp2_active = 1'b0;
    gp3_active = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_aux;
    t_branch;
    conclude;
  end
endmodule
bind pclcp_processor pclcp_asserts #(.AW(AW)) pclcp_asserts_i (
  .clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
  .mem_ack(mem_ack), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
  .xfer_total_len(xfer_total_len), .xfer_done(xfer_done),
  .pcl_irq(pcl_irq), .halt_irq(halt_irq));
